// ===== rtl/ctbl_core.sv
// Execution core for register transfer, test-branch and table lookup
`timescale 1ns/1ps
`default_nettype none
module ctbl_core
  import ctbl_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire ctbl_pkg::ctbl_byte_t fetch,
  output logic fetch_ready,
  output logic [15:0] mem_addr,
  output logic mem_read,
  input wire ctbl_pkg::ctbl_byte_t mem_rdata,
  input wire logic nmi_recognised,
  input wire logic irq_pending,
  output logic irq_take,
  output logic illegal_op,
  output ctbl_pkg::ctbl_regs_t regs
);
  import ctbl_pkg::*;

  // ----------------------------------------
  // Local state
  // ----------------------------------------
  typedef struct packed {
    ctbl_state_t st;
    ctbl_regs_t r;
    logic [15:0] op_pc;
    logic [7:0] op;
    logic page2;
    logic [7:0] pb;
    logic [15:0] ea;
    logic [7:0] y1;
    logic irq_hold;
    logic illegal;
  } ctbl_core_t;

  ctbl_core_t s_reg, s_next;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  // Counter selected by postbyte bits 2:0
  function automatic logic [15:0] sel_counter(input ctbl_regs_t r, input logic [2:0] sel);
    logic [15:0] v;
    v = 16'h0000;
    case (sel)
      CNT_A: v = {8'h00, r.a};
      CNT_B: v = {8'h00, r.b};
      CNT_D: v = {r.a, r.b};
      CNT_X: v = r.x;
      CNT_Y: v = r.y;
      CNT_SP: v = r.sp;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] n_z_flags(input logic [7:0] f, input logic [7:0] res);
    logic [7:0] o;
    o = f;
    o[F_N] = res[7];
    o[F_Z] = (res == 8'h00);
    return o;
  endfunction

  // Index register picked by a two-bit field
  function automatic logic [15:0] idx_base(input ctbl_regs_t r, input logic [1:0] sel);
    logic [15:0] v;
    v = r.x;
    case (sel)
      2'h1: v = r.y;
      2'h2: v = r.sp;
      2'h3: v = r.pc;
      default: v = r.x;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Address and arithmetic
  // ----------------------------------------
  logic [15:0] ea_calc;
  logic xb_ok;
  logic [15:0] base;
  logic [8:0] diff;
  logic signed [16:0] prod_full;
  logic [15:0] prod;
  logic [7:0] lut;
  logic [15:0] rel;
  logic cnt_zero;
  logic [7:0] newf;

  always_comb begin
    base = idx_base(s_reg.r, s_reg.pb[7:6]);
    // Five-bit constant offset or accumulator offset, no 9/16-bit, no indirect
    xb_ok = 1'b0;
    ea_calc = base;
    if (!s_reg.pb[5]) begin
      xb_ok = 1'b1;
      ea_calc = base + {{11{s_reg.pb[4]}}, s_reg.pb[4:0]};
    end else if ((s_reg.pb & XB_ACC_MASK) == XB_ACC_VAL && s_reg.pb[1:0] != 2'h3) begin
      xb_ok = 1'b1;
      // Accumulator forms name their index register in bits 4:3
      base = idx_base(s_reg.r, s_reg.pb[4:3]);
      case (s_reg.pb[1:0])
        2'h0: ea_calc = base + {8'h00, s_reg.r.a};
        2'h1: ea_calc = base + {8'h00, s_reg.r.b};
        default: ea_calc = base + {s_reg.r.a, s_reg.r.b};
      endcase
    end
    diff = {1'b0, mem_rdata.data} - {1'b0, s_reg.y1};
    // Signed step between entries times an unsigned fraction
    prod_full = $signed({1'b0, s_reg.r.b}) * $signed(diff);
    prod = prod_full[15:0];
    lut = s_reg.y1 + prod[15:8];
    rel = {{7{s_reg.pb[PB_SIGN_BIT]}}, s_reg.pb[PB_SIGN_BIT], fetch.data};
    cnt_zero = (sel_counter(s_reg.r, s_reg.pb[2:0]) == 16'h0000);
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    newf = s_reg.r.flags;
    s_next.illegal = 1'b0;
    s_next.irq_hold = 1'b0;
    fetch_ready = 1'b0;
    mem_read = 1'b0;
    mem_addr = s_reg.ea;
    case (s_reg.st)
      CT_FETCH: begin
        fetch_ready = 1'b1;
        if (fetch.valid) begin
          s_next.op = fetch.data;
          s_next.op_pc = s_reg.r.pc;
          s_next.r.pc = s_reg.r.pc + 16'h0001;
          if (s_reg.page2) begin
            s_next.page2 = 1'b0;
            s_next.op_pc = s_reg.op_pc;
            if (fetch.data == OP2_B_TO_A) begin
              s_next.r.a = s_reg.r.b;
              s_next.r.flags = n_z_flags(s_reg.r.flags, s_reg.r.b);
              s_next.r.flags[F_V] = 1'b0;
            end else if (fetch.data == OP2_TABLE) begin
              s_next.st = CT_PB;
            end else begin
              s_next.illegal = 1'b1;
            end
          end else if (fetch.data == OP_PAGE2) begin
            s_next.page2 = 1'b1;
          end else if (fetch.data == OP_GEN_MOVE || fetch.data == OP_LOOP) begin
            s_next.st = CT_PB;
          end else begin
            s_next.illegal = 1'b1;
          end
        end
      end
      CT_PB: begin
        fetch_ready = 1'b1;
        if (fetch.valid) begin
          s_next.pb = fetch.data;
          s_next.r.pc = s_reg.r.pc + 16'h0001;
          s_next.st = CT_FETCH;
          if (s_reg.op == OP_GEN_MOVE) begin
            if (fetch.data == PB_A_TO_FLAGS) begin
              newf = s_reg.r.a;
              newf[F_X] = s_reg.r.a[F_X] & s_reg.r.flags[F_X];
              s_next.r.flags = newf;
              s_next.irq_hold = s_reg.r.flags[F_I] & ~s_reg.r.a[F_I];
            end else begin
              s_next.illegal = 1'b1;
            end
          end else if (s_reg.op == OP_LOOP) begin
            if (fetch.data[PB_KIND_HI:PB_KIND_LO] == PB_KIND_TEST) s_next.st = CT_REL;
            else s_next.illegal = 1'b1;
          end else begin
            s_next.st = CT_RD1;
          end
        end
      end
      CT_REL: begin
        fetch_ready = 1'b1;
        if (fetch.valid) begin
          s_next.st = CT_FETCH;
          // Branch target from instruction start plus three
          if (cnt_zero != s_reg.pb[PB_NZ_BIT]) begin
            s_next.r.pc = s_reg.op_pc + LOOP_LEN + rel;
          end else begin
            s_next.r.pc = s_reg.r.pc + 16'h0001;
          end
        end
      end
      CT_RD1: begin
        if (!xb_ok) begin
          s_next.illegal = 1'b1;
          s_next.st = CT_FETCH;
        end else begin
          mem_addr = ea_calc;
          mem_read = 1'b1;
          s_next.ea = ea_calc + 16'h0001;
          if (mem_rdata.valid) begin
            s_next.y1 = mem_rdata.data;
            s_next.st = CT_RD2;
          end
        end
      end
      CT_RD2: begin
        mem_read = 1'b1;
        if (mem_rdata.valid) begin
          s_next.r.a = lut;
          s_next.r.flags = n_z_flags(s_reg.r.flags, lut);
          s_next.r.flags[F_C] = prod[7];
          s_next.st = CT_FETCH;
        end
      end
      default: s_next.st = CT_FETCH;
    endcase
    if (nmi_recognised) s_next.r.flags[F_X] = 1'b1;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.st <= CT_FETCH;
      s_reg.r.flags <= FLAGS_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regs = s_reg.r;
  assign illegal_op = s_reg.illegal;
  assign irq_take = irq_pending & ~s_reg.r.flags[F_I] & ~s_reg.irq_hold;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_xmask_no_set: assert property (@(posedge clock) disable iff (rst)
    (!s_reg.r.flags[F_X] && !nmi_recognised) |=> !s_reg.r.flags[F_X])
    else $error("nonmaskable mask set by software");
  a_b_to_a_copy: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_FETCH && fetch.valid && s_reg.page2 && fetch.data == OP2_B_TO_A)
    |=> (s_reg.r.a == $past(s_reg.r.b) && s_reg.r.b == $past(s_reg.r.b) && !s_reg.r.flags[F_V]))
    else $error("B to A move wrong");
  a_irq_holdoff: assert property (@(posedge clock) disable iff (rst)
    $fell(s_reg.r.flags[F_I]) |-> !irq_take)
    else $error("interrupt taken during holdoff");
  a_a_kept_tap: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_PB && fetch.valid && s_reg.op == OP_GEN_MOVE && fetch.data == PB_A_TO_FLAGS && !nmi_recognised)
    |=> (s_reg.r.a == $past(s_reg.r.a) && s_reg.r.flags[F_N] == $past(s_reg.r.a[F_N])))
    else $error("A to flags transfer wrong");
  a_branch_flags: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_REL && !nmi_recognised) |=> s_reg.r.flags == $past(s_reg.r.flags))
    else $error("test branch altered flags");
  a_fallthrough_pc: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_REL && fetch.valid && cnt_zero == s_reg.pb[PB_NZ_BIT])
    |=> s_reg.r.pc == $past(s_reg.op_pc) + 16'h0003)
    else $error("fall through address wrong");
  a_lut_result: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_RD2 && mem_rdata.valid) |=> (s_reg.r.a == $past(lut) && s_reg.st == CT_FETCH))
    else $error("table result wrong");
  a_second_addr: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_RD1 && mem_read && mem_rdata.valid) |=> mem_addr == $past(mem_addr) + 16'h0001)
    else $error("second entry address wrong");
  a_tbl_flags: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_RD2 && mem_rdata.valid && !nmi_recognised)
    |=> (s_reg.r.flags[F_N] == s_reg.r.a[7] && s_reg.r.flags[F_Z] == (s_reg.r.a == 8'h00)))
    else $error("table flags wrong");
  a_branch_target: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_REL && fetch.valid && cnt_zero != s_reg.pb[PB_NZ_BIT])
    |=> s_reg.r.pc == $past(s_reg.op_pc) + 16'h0003
      + $past({{8{s_reg.pb[PB_SIGN_BIT]}}, fetch.data}))
    else $error("branch target wrong");
  a_move_flags: assert property (@(posedge clock) disable iff (rst)
    (s_reg.st == CT_PB && fetch.valid && s_reg.op == OP_GEN_MOVE && fetch.data != PB_A_TO_FLAGS && !nmi_recognised)
    |=> s_reg.r.flags == $past(s_reg.r.flags))
    else $error("general move altered flags");
endmodule
`default_nettype wire

// ===== shared/ctbl_pkg.sv
// Package for the transfer, test-branch and table-lookup execution block
package ctbl_pkg;
  // Opcode bytes
  localparam logic [7:0] OP_GEN_MOVE = 8'hB7;
  localparam logic [7:0] OP_PAGE2 = 8'h18;
  localparam logic [7:0] OP_LOOP = 8'h04;
  localparam logic [7:0] OP2_B_TO_A = 8'h0F;
  localparam logic [7:0] OP2_TABLE = 8'h3D;
  localparam logic [7:0] PB_A_TO_FLAGS = 8'h02;
  // Loop postbyte fields
  localparam int PB_KIND_HI = 7;
  localparam int PB_KIND_LO = 6;
  localparam logic [1:0] PB_KIND_TEST = 2'h1;
  localparam int PB_NZ_BIT = 5;
  localparam int PB_SIGN_BIT = 4;
  localparam logic [2:0] CNT_A = 3'h0;
  localparam logic [2:0] CNT_B = 3'h1;
  localparam logic [2:0] CNT_D = 3'h4;
  localparam logic [2:0] CNT_X = 3'h5;
  localparam logic [2:0] CNT_Y = 3'h6;
  localparam logic [2:0] CNT_SP = 3'h7;
  localparam logic [15:0] LOOP_LEN = 16'h0003;
  // Flag bit positions
  localparam int F_S = 7;
  localparam int F_X = 6;
  localparam int F_H = 5;
  localparam int F_I = 4;
  localparam int F_N = 3;
  localparam int F_Z = 2;
  localparam int F_V = 1;
  localparam int F_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'hD0;
  // Indexed postbyte for table lookup: 5-bit offset form or accumulator form
  localparam logic [7:0] XB_ACC_MASK = 8'hE4;
  localparam logic [7:0] XB_ACC_VAL = 8'hE4;
  localparam logic [7:0] XB_ACCD_VAL = 8'hE6;

  typedef enum {CT_FETCH, CT_PB, CT_REL, CT_RD1, CT_RD2} ctbl_state_t;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] flags;
  } ctbl_regs_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ctbl_byte_t;
endpackage

// ===== verif/ctbl_core_tb.sv
// Self-checking bench for the transfer, test-branch and table core
`timescale 1ns/1ps
`default_nettype none
module ctbl_core_tb;
  import ctbl_pkg::*;
  typedef struct packed {logic [7:0] lb; logic [7:0] rr; logic take;} ctbl_row_t;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic nmi_recognised = 1'b0;
  logic irq_pending = 1'b0;
  ctbl_byte_t fetch;
  ctbl_byte_t mem_rdata;
  logic fetch_ready;
  logic mem_read;
  logic irq_take;
  logic illegal_op;
  logic [15:0] mem_addr;
  ctbl_regs_t regs;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_ill = 0;
  logic [15:0] exp_pc = 16'h0000;
  logic [15:0] rd[$];
  logic [1:0] tk;
  ctbl_row_t rows[8] = '{'{8'h40, 8'h10, 1'b0}, '{8'h60, 8'h10, 1'b1}, '{8'h41, 8'h22, 1'b1},
    '{8'h64, 8'hF0, 1'b1}, '{8'h45, 8'h05, 1'b1}, '{8'h66, 8'h33, 1'b0}, '{8'h5F, 8'hF0, 1'b1},
    '{8'h74, 8'h80, 1'b1}};
  ctbl_core dut_u (.clock(clock), .rst(rst), .fetch(fetch), .fetch_ready(fetch_ready), .mem_addr(mem_addr),
    .mem_read(mem_read), .mem_rdata(mem_rdata), .nmi_recognised(nmi_recognised), .irq_pending(irq_pending),
    .irq_take(irq_take), .illegal_op(illegal_op), .regs(regs));
  ctbl_mem_model mdl_u (.clock(clock), .rst(rst), .fetch(fetch), .fetch_ready(fetch_ready),
    .mem_addr(mem_addr), .mem_read(mem_read), .mem_rdata(mem_rdata));
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    if (illegal_op === 1'b1) n_ill++;
    if (mem_read === 1'b1 && mem_rdata.valid === 1'b1) rd.push_back(mem_addr);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Sends one instruction and waits until the core is idle
  task automatic run(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int n);
    int idle;
    int nq;
    idle = 0;
    nq = 0;
    @(negedge clock);
    mdl_u.send(b0);
    if (n > 1) mdl_u.send(b1);
    if (n > 2) mdl_u.send(b2);
    exp_pc = exp_pc + 16'(n);
    for (int k = 0; k < 40 && idle < 2; k++) begin
      @(negedge clock);
      if (mdl_u.q.size() == 0 && nq < 2) begin
        tk[nq] = irq_take;
        nq++;
      end
      if (mdl_u.q.size() == 0 && fetch_ready === 1'b1 && mem_read === 1'b0) idle++;
      else idle = 0;
    end
    if (idle < 2) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic table_interpolate(input logic [7:0] xb, input logic [15:0] ea, input logic [7:0] a, input logic [7:0] f);
    rd.delete();
    run(OP_PAGE2, OP2_TABLE, xb, 3);
    chk(16'(regs.a), 16'(a));
    chk(16'(regs.flags), 16'(f));
    chk(rd[0], ea);
    chk(rd[1], ea + 16'h0001);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    chk(16'(regs.flags), 16'h00D0);
    chk(regs.pc, 16'h0000);
    $display("test reset done");
    table_interpolate(8'h02, 16'h0002, 8'hFF, 8'hD8);
    run(OP_GEN_MOVE, PB_A_TO_FLAGS, 8'h00, 2);
    chk(16'(regs.flags), 16'h00FF);
    chk(16'(regs.a), 16'h00FF);
    table_interpolate(8'hF4, 16'h00FF, 8'hFC, 8'hFA);
    table_interpolate(8'h03, 16'h0003, 8'h00, 8'hF6);
    @(posedge clock);
    irq_pending <= 1'b1;
    run(OP_GEN_MOVE, PB_A_TO_FLAGS, 8'h00, 2);
    chk(16'(regs.flags), 16'h0000);
    chk(16'(tk), 16'h0002);
    table_interpolate(8'h02, 16'h0002, 8'hFF, 8'h08);
    run(OP_GEN_MOVE, PB_A_TO_FLAGS, 8'h00, 2);
    chk(16'(regs.flags), 16'h00BF);
    @(posedge clock);
    nmi_recognised <= 1'b1;
    @(posedge clock);
    nmi_recognised <= 1'b0;
    @(negedge clock);
    chk(16'(regs.flags), 16'h00FF);
    $display("test flag transfer done");
    for (int i = 0; i < 8; i++) begin
      run(OP_LOOP, rows[i].lb, rows[i].rr, 3);
      if (rows[i].take) exp_pc = exp_pc + {{8{rows[i].lb[PB_SIGN_BIT]}}, rows[i].rr};
      chk(regs.pc, exp_pc);
      chk(16'(regs.flags), 16'h00FF);
    end
    $display("test branch rows done");
    run(OP_PAGE2, OP2_B_TO_A, 8'h00, 2);
    chk(16'(regs.a), 16'h0000);
    chk(16'(regs.b), 16'h0000);
    chk(16'(regs.flags), 16'h00F5);
    run(OP_GEN_MOVE, 8'h03, 8'h00, 2);
    chk(16'(n_ill), 16'h0001);
    chk(16'(regs.flags), 16'h00F5);
    run(OP_LOOP, 8'h80, 8'h00, 2);
    chk(16'(n_ill), 16'h0002);
    rd.delete();
    run(OP_PAGE2, OP2_TABLE, 8'hE7, 3);
    chk(16'(n_ill), 16'h0003);
    chk(16'(rd.size()), 16'h0000);
    $display("test refusals done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== verif/ctbl_mem_model.sv
// Instruction stream and data memory model for the execution core
`timescale 1ns/1ps
`default_nettype none
module ctbl_mem_model (
  input wire logic clock,
  input wire logic rst,
  output ctbl_pkg::ctbl_byte_t fetch,
  input wire logic fetch_ready,
  input wire logic [15:0] mem_addr,
  input wire logic mem_read,
  output ctbl_pkg::ctbl_byte_t mem_rdata
);
  import ctbl_pkg::*;
  logic [7:0] q[$];
  task automatic send(input logic [7:0] b);
    q.push_back(b);
  endtask
  initial begin
    fetch = '0;
    mem_rdata = '0;
  end
  // Reads wait one cycle; idle lines toggle
  always @(posedge clock) begin
    if (rst) begin
      q.delete();
      fetch <= '0;
      mem_rdata <= '0;
    end else begin
      if (fetch.valid && fetch_ready) void'(q.pop_front());
      if (q.size() != 0) fetch <= {1'b1, q[0]};
      else fetch <= {1'b0, ~fetch.data};
      if (mem_read && !mem_rdata.valid) mem_rdata <= {1'b1, mem_addr[7:0] + 8'hFD};
      else mem_rdata <= {1'b0, ~mem_rdata.data};
    end
  end
endmodule
`default_nettype wire
